/* File: inc/cbx_pkg.sv */
package cbx_pkg;

  // ------------------------------------------------------------
  // Operation forms of the byte move and byte exchange group
  // ------------------------------------------------------------
  typedef enum logic [5:0] {
    MV_R_IMM, MV_S_IMM, MV_F_IMM, MV_A_R, MV_R_A, MV_A_S, MV_S_A,
    MV_A_F, MV_F_A, MV_A_ABS, MV_ABS_A, MV_P_IMM, MV_A_P, MV_P_A,
    MV_A_DE, MV_DE_A, MV_A_HL, MV_HL_A, MV_A_HLD, MV_HLD_A,
    MV_A_HLB, MV_HLB_A, MV_A_HLC, MV_HLC_A,
    XC_A_R, XC_A_S, XC_A_F, XC_A_ABS, XC_A_DE, XC_A_HL,
    XC_A_HLD, XC_A_HLB, XC_A_HLC
  } cbx_op_t;

  // Decoded instruction handed to the execution unit.
  typedef struct packed {
    cbx_op_t     op;
    logic [2:0]  regIdx;
    logic [7:0]  imm;
    logic [15:0] addr;
  } cbx_instr_t;

  // Data space request toward RAM and peripheral registers.
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } cbx_mem_req_t;

  // ------------------------------------------------------------
  // Address windows
  // ------------------------------------------------------------
  localparam logic [15:0] SADDR_LO   = 16'hFE20;
  localparam logic [15:0] SADDR_HI   = 16'hFF1F;
  localparam logic [7:0]  SADDR_WRAP = 8'h20;
  localparam logic [7:0]  PAGE_FE    = 8'hFE;
  localparam logic [7:0]  PAGE_FF    = 8'hFF;
  localparam logic [15:0] SFR_BASE   = 16'hFF00;
  localparam logic [15:0] SFR_RSV_LO = 16'hFFD0;
  localparam logic [15:0] SFR_RSV_HI = 16'hFFDF;
  localparam logic [15:0] CALL_BASE  = 16'h0800;
  localparam logic [15:0] TABLE_BASE = 16'h0040;
  localparam logic [15:0] HSRAM_LO   = 16'hFB00;
  localparam logic [15:0] HSRAM_HI   = 16'hFF1F;

  // ------------------------------------------------------------
  // Register indices, reset values and sequence steps
  // ------------------------------------------------------------
  localparam logic [2:0] IDX_X     = 3'h0;
  localparam logic [2:0] IDX_A     = 3'h1;
  localparam logic [2:0] IDX_C     = 3'h2;
  localparam logic [2:0] IDX_B     = 3'h3;
  localparam logic [2:0] IDX_E     = 3'h4;
  localparam logic [2:0] IDX_D     = 3'h5;
  localparam logic [2:0] IDX_L     = 3'h6;
  localparam logic [2:0] IDX_H     = 3'h7;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] PSW_RESET = 8'h02;
  localparam logic [3:0] STEP_RD   = 4'h1;
  localparam logic [3:0] STEP_CAP  = 4'h2;
  localparam logic [3:0] STEP_WR   = 4'h3;
  localparam logic [3:0] CNT_LAST  = 4'h1;

  // Length in bytes, clocks on fast access, clocks otherwise.
  function automatic logic [9:0] op_timing(input cbx_op_t op);
    case (op)
      MV_R_IMM:                      op_timing = {2'h2, 4'h4, 4'h4};
      MV_S_IMM:                      op_timing = {2'h3, 4'h6, 4'h7};
      MV_F_IMM, MV_P_IMM:            op_timing = {2'h3, 4'h7, 4'h7};
      MV_A_R, MV_R_A, XC_A_R:        op_timing = {2'h1, 4'h2, 4'h2};
      MV_A_S, MV_S_A:                op_timing = {2'h2, 4'h4, 4'h5};
      MV_A_F, MV_F_A, MV_A_P, MV_P_A: op_timing = {2'h2, 4'h5, 4'h5};
      MV_A_ABS, MV_ABS_A:            op_timing = {2'h3, 4'h8, 4'h9};
      MV_A_DE, MV_DE_A, MV_A_HL, MV_HL_A: op_timing = {2'h1, 4'h4, 4'h5};
      MV_A_HLD, MV_HLD_A:            op_timing = {2'h2, 4'h8, 4'h9};
      MV_A_HLB, MV_HLB_A, MV_A_HLC, MV_HLC_A: op_timing = {2'h1, 4'h6, 4'h7};
      XC_A_S:                        op_timing = {2'h2, 4'h4, 4'h6};
      XC_A_F:                        op_timing = {2'h2, 4'h6, 4'h6};
      XC_A_DE, XC_A_HL:              op_timing = {2'h1, 4'h4, 4'h6};
      XC_A_ABS, XC_A_HLD, XC_A_HLB, XC_A_HLC: op_timing = {op == XC_A_ABS ? 2'h3 : 2'h2, 4'h8, 4'hA};
      default:                       op_timing = {2'h1, 4'h2, 4'h2};
    endcase
  endfunction

endpackage

/* File: hw/cbx_byte_xfer.sv */
`timescale 1ns/10ps
module cbx_byte_xfer
(
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst_b,
  // Instruction handshake
  input  wire logic                 instrValid,
  output logic                      instrReady,
  input  wire cbx_pkg::cbx_instr_t  instr,
  output logic                      instrDone,
  output logic                      instrFault,
  output logic [1:0]                instrLen,
  output logic [3:0]                instrClocks,
  // Data space
  output cbx_pkg::cbx_mem_req_t     memReq,
  input  wire logic [7:0]           memRdata,
  // Status and accumulators
  input  wire logic                 flagRestore,
  input  wire logic [7:0]           savedPsw,
  output logic [7:0]                programStatusWord,
  output logic [7:0]                accumulator,
  input  wire logic [1:0]           pairSel,
  output logic [15:0]               pairData,
  output logic                      irqHold,
  // Operand range checks
  input  wire logic [10:0]          callFieldOperand,
  output logic [15:0]               callTarget,
  input  wire logic [4:0]           callTableOperand,
  output logic [15:0]               tableTarget,
  input  wire logic [15:0]          wordOperand,
  output logic                      wordSaddrOk,
  output logic                      wordSfrOk
);

  // ------------------------------------------------------------
  // State and storage
  // ------------------------------------------------------------
  typedef enum logic {ST_IDLE, ST_EXEC} cbx_state_t;

  cbx_state_t          state;
  cbx_pkg::cbx_instr_t cur;
  logic [7:0]          regs [8];
  logic [3:0]          cnt;
  logic [3:0]          step;
  logic [15:0]         memAddr;
  logic [7:0]          memWdata;
  logic [7:0]          rdCap;
  logic                curRd;
  logic                curWr;
  logic                curXch;

  logic                accept;
  logic                finish;
  logic [15:0]         regHL;
  logic [15:0]         regDE;
  logic [15:0]         decAddr;
  logic                decMem;
  logic                decRd;
  logic                decWr;
  logic                decSfr;
  logic                decFault;
  logic                decFast;
  logic [9:0]          timing;
  logic                aWr;
  logic [7:0]          aVal;
  logic                rWr;
  logic [7:0]          rVal;

  assign regHL = {regs[cbx_pkg::IDX_H], regs[cbx_pkg::IDX_L]};
  assign regDE = {regs[cbx_pkg::IDX_D], regs[cbx_pkg::IDX_E]};

  // ------------------------------------------------------------
  // Operand decode of the offered instruction
  // ------------------------------------------------------------
  // Address of the data operand, and which way the access goes.
  always_comb
  begin
    decAddr = 16'h0000;
    decMem  = 1'b1;
    decSfr  = 1'b0;
    case (instr.op)
      cbx_pkg::MV_S_IMM, cbx_pkg::MV_A_S, cbx_pkg::MV_S_A, cbx_pkg::XC_A_S:
        // Low offsets wrap into the FF page, so the window is closed; the offset rides in
        // the low address byte so that imm stays free for an immediate store's data.
        decAddr = (instr.addr[7:0] >= cbx_pkg::SADDR_WRAP) ? {cbx_pkg::PAGE_FE, instr.addr[7:0]}
                                                           : {cbx_pkg::PAGE_FF, instr.addr[7:0]};
      cbx_pkg::MV_F_IMM, cbx_pkg::MV_A_F, cbx_pkg::MV_F_A, cbx_pkg::XC_A_F:
      begin
        decAddr = cbx_pkg::SFR_BASE | {8'h00, instr.addr[7:0]};
        decSfr  = 1'b1;
      end
      cbx_pkg::MV_A_ABS, cbx_pkg::MV_ABS_A, cbx_pkg::XC_A_ABS:
        decAddr = instr.addr;
      cbx_pkg::MV_A_DE, cbx_pkg::MV_DE_A, cbx_pkg::XC_A_DE:
        decAddr = regDE;
      cbx_pkg::MV_A_HL, cbx_pkg::MV_HL_A, cbx_pkg::XC_A_HL:
        decAddr = regHL;
      cbx_pkg::MV_A_HLD, cbx_pkg::MV_HLD_A, cbx_pkg::XC_A_HLD:
        decAddr = regHL + {8'h00, instr.imm};
      cbx_pkg::MV_A_HLB, cbx_pkg::MV_HLB_A, cbx_pkg::XC_A_HLB:
        decAddr = regHL + {8'h00, regs[cbx_pkg::IDX_B]};
      cbx_pkg::MV_A_HLC, cbx_pkg::MV_HLC_A, cbx_pkg::XC_A_HLC:
        decAddr = regHL + {8'h00, regs[cbx_pkg::IDX_C]};
      default:
        decMem = 1'b0;
    endcase
  end

  // Direction of the access; exchanges both read and write.
  assign decRd = decMem && (instr.op inside {cbx_pkg::MV_A_S, cbx_pkg::MV_A_F, cbx_pkg::MV_A_ABS,
                 cbx_pkg::MV_A_DE, cbx_pkg::MV_A_HL, cbx_pkg::MV_A_HLD, cbx_pkg::MV_A_HLB,
                 cbx_pkg::MV_A_HLC} || instr.op >= cbx_pkg::XC_A_S);
  assign decWr = decMem && !(decRd && instr.op < cbx_pkg::XC_A_S);

  // A reserved peripheral address in a peripheral operand form is refused outright.
  assign decFault = decSfr && decAddr >= cbx_pkg::SFR_RSV_LO && decAddr <= cbx_pkg::SFR_RSV_HI;

  // Internal high-speed RAM or no data access earns the short count.
  assign decFast = !decMem || (decAddr >= cbx_pkg::HSRAM_LO && decAddr <= cbx_pkg::HSRAM_HI);
  assign timing  = cbx_pkg::op_timing(instr.op);

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  assign instrReady = (state == ST_IDLE);
  assign accept     = instrValid && instrReady && !decFault;
  assign finish     = (state == ST_EXEC) && (cnt == cbx_pkg::CNT_LAST);

  // The accept cycle is the first instruction clock of the count.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= ST_IDLE;
      cnt   <= 4'h0;
      step  <= 4'h0;
    end
    else if (accept)
    begin
      state <= ST_EXEC;
      cnt   <= (decFast ? timing[7:4] : timing[3:0]) - 4'h1;
      step  <= cbx_pkg::STEP_RD;
    end
    else if (finish)
      state <= ST_IDLE;
    else if (state == ST_EXEC)
    begin
      cnt  <= cnt - 4'h1;
      step <= step + 4'h1;
    end
  end

  // Latched copy of the accepted instruction and its access.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cur         <= '0;
      memAddr     <= 16'h0000;
      memWdata    <= 8'h00;
      curRd       <= 1'b0;
      curWr       <= 1'b0;
      curXch      <= 1'b0;
      instrLen    <= 2'h0;
      instrClocks <= 4'h0;
    end
    else if (accept)
    begin
      cur         <= instr;
      memAddr     <= decAddr;
      // Immediate stores carry the byte; all others store A.
      memWdata    <= (instr.op inside {cbx_pkg::MV_S_IMM, cbx_pkg::MV_F_IMM}) ? instr.imm
                     : regs[cbx_pkg::IDX_A];
      curRd       <= decRd;
      curWr       <= decWr;
      curXch      <= (instr.op >= cbx_pkg::XC_A_R);
      instrLen    <= timing[9:8];
      instrClocks <= decFast ? timing[7:4] : timing[3:0];
    end
  end

  // Read data arrives one clock after the read strobe.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      rdCap <= 8'h00;
    else if (state == ST_EXEC && step == cbx_pkg::STEP_CAP && curRd)
      rdCap <= memRdata;
  end

  // Read first, then write, so an exchange sees the old value.
  assign memReq = '{rd: (state == ST_EXEC) && curRd && step == cbx_pkg::STEP_RD,
                    wr: (state == ST_EXEC) && curWr && step == cbx_pkg::STEP_WR,
                    addr: memAddr,
                    wdata: memWdata};

  // Interrupts wait until the exchange has written back.
  assign irqHold = (state == ST_EXEC) && curXch;

  // Completion and refusal pulses.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      instrDone  <= 1'b0;
      instrFault <= 1'b0;
    end
    else
    begin
      instrDone  <= finish;
      instrFault <= instrValid && instrReady && decFault;
    end
  end

  // ------------------------------------------------------------
  // Register write-back
  // ------------------------------------------------------------
  // Values written to A and to the named register at the last clock.
  always_comb
  begin
    aWr  = 1'b0;
    aVal = rdCap;
    rWr  = 1'b0;
    rVal = regs[cbx_pkg::IDX_A];
    case (cur.op)
      cbx_pkg::MV_A_R:
      begin
        aWr  = 1'b1;
        aVal = regs[cur.regIdx];
      end
      cbx_pkg::XC_A_R:
      begin
        aWr  = 1'b1;
        aVal = regs[cur.regIdx];
        rWr  = 1'b1;
      end
      cbx_pkg::MV_R_A:
        rWr = 1'b1;
      cbx_pkg::MV_R_IMM:
      begin
        rWr  = 1'b1;
        rVal = cur.imm;
      end
      cbx_pkg::MV_A_P:
      begin
        aWr  = 1'b1;
        aVal = programStatusWord;
      end
      default:
        aWr = curRd;
    endcase
  end

  // One flip-flop byte per register, indexed by the operand field.
  for (genvar i = 0; i < 8; i++)
  begin : g_reg
    localparam logic [2:0] IDX = 3'(i);
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
      if (!rst_b)
        regs[i] <= cbx_pkg::REG_RESET;
      else if (finish && aWr && IDX == cbx_pkg::IDX_A)
        regs[i] <= aVal;
      else if (finish && rWr && IDX == cur.regIdx)
        regs[i] <= rVal;
    end
  end

  // Status word: whole byte moves update Z, AC and CY together.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      programStatusWord <= cbx_pkg::PSW_RESET;
    else if (finish && cur.op == cbx_pkg::MV_P_IMM)
      programStatusWord <= cur.imm;
    else if (finish && cur.op == cbx_pkg::MV_P_A)
      programStatusWord <= regs[cbx_pkg::IDX_A];
    else if (flagRestore && state == ST_IDLE)
      programStatusWord <= savedPsw;
  end

  // ------------------------------------------------------------
  // Accumulator views
  // ------------------------------------------------------------
  // Pair p is high byte 2p+1 over low byte 2p, so AX is A over X.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      accumulator <= 8'h00;
      pairData    <= 16'h0000;
    end
    else
    begin
      accumulator <= regs[cbx_pkg::IDX_A];
      pairData    <= {regs[{pairSel, 1'b1}], regs[{pairSel, 1'b0}]};
    end
  end

  // ------------------------------------------------------------
  // Operand range checks
  // ------------------------------------------------------------
  // Targets are built from the field so they cannot leave the window.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      callTarget  <= 16'h0000;
      tableTarget <= 16'h0000;
      wordSaddrOk <= 1'b0;
      wordSfrOk   <= 1'b0;
    end
    else
    begin
      callTarget  <= cbx_pkg::CALL_BASE | {5'h00, callFieldOperand};
      tableTarget <= cbx_pkg::TABLE_BASE | {10'h000, callTableOperand, 1'b0};
      wordSaddrOk <= !wordOperand[0] && wordOperand >= cbx_pkg::SADDR_LO
                     && wordOperand <= cbx_pkg::SADDR_HI;
      // Which word registers exist is not known here; parity and window are.
      wordSfrOk   <= !wordOperand[0] && wordOperand >= cbx_pkg::SFR_BASE
                     && !(wordOperand >= cbx_pkg::SFR_RSV_LO && wordOperand <= cbx_pkg::SFR_RSV_HI);
    end
  end

endmodule

/* File: testbench/cbx_byte_xfer_sva.sv */
`timescale 1ns/10ps
module cbx_byte_xfer_sva
(
  // Clock and reset
  input wire logic                ref_clk,
  input wire logic                rst_b,
  // Instruction handshake
  input wire logic                instrValid,
  input wire logic                instrReady,
  input wire cbx_pkg::cbx_instr_t instr,
  input wire logic                instrDone,
  input wire logic                instrFault,
  input wire logic [1:0]          instrLen,
  input wire logic [3:0]          instrClocks,
  input wire logic                irqHold,
  // Operand range checks
  input wire logic [10:0]         callFieldOperand,
  input wire logic [15:0]         callTarget,
  input wire logic [4:0]          callTableOperand,
  input wire logic [15:0]         tableTarget,
  input wire logic [15:0]         wordOperand,
  input wire logic                wordSaddrOk,
  input wire logic                wordSfrOk
);
  // ------------------------------------------------------------
  // Helper logic
  // ------------------------------------------------------------
  logic       take;
  logic       reserved;
  logic       hsram;
  logic       xcMem;
  logic [3:0] sinceTake;
  logic [1:0] warm;

  // Decode the offer the way the ports see it.
  assign take     = instrValid && instrReady;
  assign reserved = (instr.op inside {cbx_pkg::MV_F_IMM, cbx_pkg::MV_A_F, cbx_pkg::MV_F_A, cbx_pkg::XC_A_F})
                    && {cbx_pkg::PAGE_FF, instr.addr[7:0]} >= cbx_pkg::SFR_RSV_LO
                    && {cbx_pkg::PAGE_FF, instr.addr[7:0]} <= cbx_pkg::SFR_RSV_HI;
  assign hsram    = instr.addr >= cbx_pkg::HSRAM_LO && instr.addr <= cbx_pkg::HSRAM_HI;
  assign xcMem    = instr.op inside {cbx_pkg::XC_A_S, cbx_pkg::XC_A_ABS, cbx_pkg::XC_A_DE, cbx_pkg::XC_A_HL,
                                     cbx_pkg::XC_A_HLD, cbx_pkg::XC_A_HLB, cbx_pkg::XC_A_HLC};

  // Counts clocks since the last accepted offer; saturates so it never wraps into a false match.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      sinceTake <= 4'h0;
    else if (take && !reserved)
      sinceTake <= 4'h1;
    else if (sinceTake != 4'hF)
      sinceTake <= sinceTake + 4'h1;
  end

  // Operand outputs lag one cycle, so they are judged only once two edges have passed.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      warm <= 2'h0;
    else if (warm != 2'h3)
      warm <= warm + 2'h1;
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  a_done_count: assert property (instrDone |-> sinceTake == instrClocks)
    else $error("done pulse not at the chosen clock count");
  a_hlb_timing: assert property (take && instr.op == cbx_pkg::MV_A_HLB |=>
    instrLen == 2'h1 && (instrClocks == 4'h6 || instrClocks == 4'h7))
    else $error("indexed load by B has wrong length or clocks");
  a_hld_timing: assert property (take && instr.op == cbx_pkg::MV_A_HLD |=>
    instrLen == 2'h2 && (instrClocks == 4'h8 || instrClocks == 4'h9))
    else $error("displaced load has wrong length or clocks");
  a_xhd_timing: assert property (take && instr.op == cbx_pkg::XC_A_HLD |=>
    instrLen == 2'h2 && (instrClocks == 4'h8 || instrClocks == 4'hA))
    else $error("displaced exchange has wrong length or clocks");
  a_fast_select: assert property (take && instr.op == cbx_pkg::MV_A_ABS |=>
    instrClocks == ($past(hsram) ? 4'h8 : 4'h9))
    else $error("fast or slow count chosen wrongly");
  a_sfr_refuse: assert property (take && reserved |=> instrFault && instrReady)
    else $error("reserved peripheral operand was not refused");
  a_xch_atomic: assert property (take && !reserved && xcMem |=> irqHold [*3])
    else $error("exchange left interrupts open");
  a_call_range: assert property (warm >= 2'h2 |-> callTarget == {5'h01, $past(callFieldOperand)})
    else $error("call target outside its window");
  a_table_even: assert property (warm >= 2'h2 |->
    tableTarget == 16'h0040 + {10'h000, $past(callTableOperand), 1'b0})
    else $error("table target not even inside its window");
  a_saddr_word: assert property (warm >= 2'h2 |-> wordSaddrOk == ($past(wordOperand) >= 16'hFE20
    && $past(wordOperand) <= 16'hFF1F && !$past(wordOperand[0])))
    else $error("short direct word check wrong");
  a_sfr_word: assert property (warm >= 2'h2 && wordSfrOk |-> !$past(wordOperand[0])
    && !($past(wordOperand) >= 16'hFFD0 && $past(wordOperand) <= 16'hFFDF))
    else $error("word peripheral check passed a bad address");

  // Main scenarios reached.
  c_done: cover property (instrDone);
  c_fault: cover property (instrFault);
  c_xch: cover property (take && xcMem ##1 irqHold);
endmodule

bind cbx_byte_xfer cbx_byte_xfer_sva chk (.ref_clk, .rst_b, .instrValid, .instrReady, .instr, .instrDone,
  .instrFault, .instrLen, .instrClocks, .irqHold, .callFieldOperand, .callTarget, .callTableOperand,
  .tableTarget, .wordOperand, .wordSaddrOk, .wordSfrOk);

/* File: testbench/cbx_mem_model.sv */
`timescale 1ns/10ps
module cbx_mem_model
(
  // Clock and reset
  input wire logic                  ref_clk,
  input wire logic                  rst_b,
  // Data space
  input wire cbx_pkg::cbx_mem_req_t memReq,
  output logic [7:0]                memRdata
);
  logic [7:0] mem [logic [15:0]];

  // Unwritten bytes read as a pattern of their address; between reads the line toggles
  // so that a stale value is never mistaken for fresh data.
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      memRdata <= 8'hA5;
    else if (memReq.rd)
      memRdata <= mem.exists(memReq.addr) ? mem[memReq.addr] : memReq.addr[7:0] ^ memReq.addr[15:8];
    else
      memRdata <= ~memRdata;
    if (rst_b && memReq.wr)
      mem[memReq.addr] = memReq.wdata;
  end
endmodule

/* File: testbench/cbx_byte_xfer_tb_top.sv */
`timescale 1ns/10ps
module cbx_byte_xfer_tb_top;
  typedef struct packed {logic flt; logic [1:0] len; logic [3:0] clk; logic chk; logic [7:0] acc;} cbx_note_t;
  logic                   ref_clk = 1'b0;
  logic                   rst_b = 1'b0;
  logic                   instrValid = 1'b0;
  cbx_pkg::cbx_instr_t    instr = '0;
  logic                   flagRestore = 1'b0;
  logic [7:0]             savedPsw = 8'h00;
  logic [1:0]             pairSel = 2'h0;
  logic [10:0]            callFieldOperand = 11'h000;
  logic [4:0]             callTableOperand = 5'h00;
  logic [15:0]            wordOperand = 16'h0000;
  logic                   instrReady, instrDone, instrFault, irqHold, wordSaddrOk, wordSfrOk;
  logic [1:0]             instrLen;
  logic [3:0]             instrClocks;
  logic [7:0]             memRdata, programStatusWord, accumulator, accExp, oldA;
  logic [15:0]            pairData, callTarget, tableTarget, a;
  cbx_pkg::cbx_mem_req_t  memReq;
  cbx_note_t              notes[$];
  cbx_note_t              n;
  int                     n_mismatch = 0;
  int                     comparisons = 0;
  int                     seed = 9;
  logic [7:0]             regVal [8] = '{8'h3C, 8'hC3, 8'h12, 8'h00, 8'h34, 8'h56, 8'h00, 8'hFE};

  always #25 ref_clk = ~ref_clk;

  cbx_byte_xfer uut (.ref_clk, .rst_b, .instrValid, .instrReady, .instr, .instrDone, .instrFault, .instrLen,
    .instrClocks, .memReq, .memRdata, .flagRestore, .savedPsw, .programStatusWord, .accumulator, .pairSel,
    .pairData, .irqHold, .callFieldOperand, .callTarget, .callTableOperand, .tableTarget, .wordOperand,
    .wordSaddrOk, .wordSfrOk);
  cbx_mem_model mem (.ref_clk, .rst_b, .memReq, .memRdata);

  // ------------------------------------------------------------
  // Checking helpers
  // ------------------------------------------------------------
  task test_done;
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task cmpVal(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // A wait that runs out is a failure and ends the run at once.
  task hang(input string what);
    n_mismatch++;
    $display("Error %s expected completion seen timeout", what);
    test_done();
  endtask

  function automatic logic [7:0] memVal(input logic [15:0] ad);
    return ad[7:0] ^ ad[15:8];
  endfunction

  // Offers one instruction, notes the expected answer at the taking edge, then waits until idle.
  task issue(input cbx_pkg::cbx_op_t op, input logic [2:0] ri, input logic [7:0] imm, input logic [15:0] ad,
             input logic [1:0] len, input logic [3:0] clk, input logic chk, input logic flt);
    int i;
    instr = '{op: op, regIdx: ri, imm: imm, addr: ad};
    instrValid = 1'b1;
    for (i = 0; !instrReady; i++)
    begin
      if (i > 40) hang("offer");
      @(posedge ref_clk);
      #2;
    end
    @(posedge ref_clk);
    notes.push_back('{flt: flt, len: len, clk: clk, chk: chk, acc: accExp});
    #2 instrValid = 1'b0;
    // At least one edge passes, so valid never drops and rises again in one step.
    for (i = 0; i == 0 || notes.size() != 0 || !instrReady; i++)
    begin
      if (i > 40) hang("completion");
      @(posedge ref_clk);
      #2;
    end
  endtask

  task step(input int k);
    repeat (k) @(posedge ref_clk);
    #2;
  endtask

  // Takes the oldest note whenever a completion or a refusal shows.
  initial forever
  begin
    @(posedge ref_clk);
    #1;
    if (instrDone === 1'b1 || instrFault === 1'b1)
    begin
      if (notes.size() == 0)
        cmpVal("unexpected result", 16'h0, 16'h1);
      else
      begin
        n = notes.pop_front();
        cmpVal("fault", n.flt, instrFault);
        if (!n.flt) cmpVal("length", n.len, instrLen);
        if (!n.flt) cmpVal("clocks", n.clk, instrClocks);
        if (n.chk) @(posedge ref_clk);
        if (n.chk) #1 cmpVal("accumulator", n.acc, accumulator);
      end
    end
  end

  initial
  begin
    #(50 * 20000);
    hang("run");
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    step(20);
    rst_b = 1'b1;
    step(1);
    for (int i = 0; i < 8; i++)
      issue(cbx_pkg::cbx_op_t'(cbx_pkg::MV_R_IMM), 3'(i), regVal[i], 16'h0, 2'h2, 4'h4, 1'b0, 1'b0);
    for (int p = 0; p < 4; p++)
    begin
      pairSel = 2'(p);
      step(2);
      cmpVal("pair", {regVal[2 * p + 1], regVal[2 * p]}, pairData);
    end
    $display("Test registers finished");
    accExp = regVal[1];
    for (int k = 0; k < 6; k++)
    begin
      a = 16'($random(seed));
      a = k[0] ? 16'hFB00 + {6'h00, a[9:0]} : {1'b0, a[14:0]};
      accExp = memVal(a);
      issue(cbx_pkg::MV_A_ABS, 3'h0, 8'h00, a, 2'h3, k[0] ? 4'h8 : 4'h9, 1'b1, 1'b0);
    end
    $display("Test absolute finished");
    for (int s = 0; s < 2; s++)
    begin
      a = s ? 16'h1200 : 16'hFE00;
      accExp = memVal(a);
      issue(cbx_pkg::MV_A_HLB, 3'h0, 8'h00, a, 2'h1, s ? 4'h7 : 4'h6, 1'b1, 1'b0);
      accExp = memVal(a + 16'h20);
      issue(cbx_pkg::MV_A_HLD, 3'h0, 8'h20, a + 16'h20, 2'h2, s ? 4'h9 : 4'h8, 1'b1, 1'b0);
      oldA = accExp;
      accExp = memVal(a + 16'h30);
      issue(cbx_pkg::XC_A_HLD, 3'h0, 8'h30, a + 16'h30, 2'h2, s ? 4'hA : 4'h8, 1'b1, 1'b0);
      accExp = oldA;
      issue(cbx_pkg::MV_A_HLD, 3'h0, 8'h30, a + 16'h30, 2'h2, s ? 4'h9 : 4'h8, 1'b1, 1'b0);
      issue(cbx_pkg::MV_R_IMM, cbx_pkg::IDX_H, 8'h12, 16'h0, 2'h2, 4'h4, 1'b0, 1'b0);
    end
    $display("Test indexed finished");
    for (int k = 0; k < 4; k++)
    begin
      a = 16'hFFD0 | 16'($random(seed) & 15);
      issue(k == 0 ? cbx_pkg::MV_A_F : k == 1 ? cbx_pkg::MV_F_A : k == 2 ? cbx_pkg::XC_A_F : cbx_pkg::MV_F_IMM,
            3'h0, 8'h00, a, 2'h0, 4'h0, 1'b0, 1'b1);
    end
    issue(cbx_pkg::MV_F_A, 3'h0, 8'h00, 16'hFFC0, 2'h2, 4'h5, 1'b0, 1'b0);
    $display("Test reserved finished");
    savedPsw = 8'($random(seed));
    flagRestore = 1'b1;
    step(2);
    cmpVal("status word", savedPsw, programStatusWord);
    flagRestore = 1'b0;
    issue(cbx_pkg::MV_P_IMM, 3'h0, 8'h5A, 16'h0, 2'h3, 4'h7, 1'b0, 1'b0);
    accExp = 8'h5A;
    issue(cbx_pkg::MV_A_P, 3'h0, 8'h00, 16'h0, 2'h2, 4'h5, 1'b1, 1'b0);
    accExp = 8'h12;
    issue(cbx_pkg::MV_A_R, cbx_pkg::IDX_C, 8'h00, 16'h0, 2'h1, 4'h2, 1'b1, 1'b0);
    issue(cbx_pkg::MV_S_IMM, 3'h0, 8'h77, 16'hFE80, 2'h3, 4'h6, 1'b0, 1'b0);
    accExp = 8'h77;
    issue(cbx_pkg::MV_A_S, 3'h0, 8'h00, 16'hFE80, 2'h2, 4'h4, 1'b1, 1'b0);
    cmpVal("status word", 16'h005A, {8'h00, programStatusWord});
    for (int k = 0; k < 6; k++)
    begin
      callFieldOperand = 11'($random(seed));
      callTableOperand = 5'($random(seed));
      wordOperand = k < 3 ? 16'hFE1F + 16'(k) * 16'h7F : k == 3 ? 16'hFF20 : k == 4 ? 16'hFFD4 : 16'($random(seed));
      step(2);
      cmpVal("call target", {5'h01, callFieldOperand}, callTarget);
      cmpVal("table target", 16'h0040 + {10'h000, callTableOperand, 1'b0}, tableTarget);
      cmpVal("short word", 16'(wordOperand >= 16'hFE20 && wordOperand <= 16'hFF1F && !wordOperand[0]),
             16'(wordSaddrOk));
      cmpVal("sfr word", 16'(!wordOperand[0] && wordOperand >= cbx_pkg::SFR_BASE && !(wordOperand >= cbx_pkg::SFR_RSV_LO
             && wordOperand <= cbx_pkg::SFR_RSV_HI)), 16'(wordSfrOk));
    end
    $display("Test operands finished");
    test_done();
  end
endmodule
